/* File: hdl/pch_pkg.sv */
// Constants for the type-zero configuration header register bank
// Overview of operation
// (RL1) Target abort sets status bit 12
// (RL2) Master abort sets status bit 13
// (RL3) System error signalled sets status bit 14
// (RL4) Any parity error sets status bit 15
// (RL5) Writing one clears flag; zero keeps it
// (RL6) Revision code read-only, build-time parameter
// (RL7) Class code 24-bit read-only, default FF0000
// (RL8) Latency timer bits 7..3 writable, 2..0 zero
// (RL9) Master transaction decrements timer every clock
// (RL10) Header type reads 00, read-only
// (RL11) Window base has n writable upper bits
// (RL12) Sizing readback shows zeros in lower bits
// (RL13) Base bits 3..0 read zero: memory, anywhere
// (RL14) Board maker code read-only build-time parameter
// (RL15) Board variant code read-only build-time parameter
// (RL16) Interrupt route read/write, resets to FF
// (RL17) Interrupt pin reads 01, read-only
// (RL18) Minimum grant reads 10, read-only
// (RL19) Maximum latency reads 00, read-only
// (RL20) Master data phases use all byte enables
// (RL21) Target window writes honour byte enables
// (RL22) Unimplemented offsets read zero, ignore writes
package pch_pkg;

    // ------------------------------------------------------------
    // Printed byte offsets of the header fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_STATUS = 8'h06;
    localparam logic [7:0] OFS_REVISION = 8'h08;
    localparam logic [7:0] OFS_CATEGORY = 8'h09;
    localparam logic [7:0] OFS_HOLD_TIMER = 8'h0D;
    localparam logic [7:0] OFS_HEADER = 8'h0E;
    localparam logic [7:0] OFS_WINDOW = 8'h10;
    localparam logic [7:0] OFS_MAKER = 8'h2C;
    localparam logic [7:0] OFS_VARIANT = 8'h2E;
    localparam logic [7:0] OFS_IRQ_ROUTE = 8'h3C;
    localparam logic [7:0] OFS_IRQ_PIN = 8'h3D;
    localparam logic [7:0] OFS_BURST = 8'h3E;
    localparam logic [7:0] OFS_INTERVAL = 8'h3F;

    // ------------------------------------------------------------
    // Status flag positions within the 16-bit status field
    // ------------------------------------------------------------
    localparam int BIT_TGT_ABORT = 12;
    localparam int BIT_MST_ABORT = 13;
    localparam int BIT_SYS_ERR = 14;
    localparam int BIT_PAR_ERR = 15;
    localparam int STATUS_LANE_LSB = 16;

    // ------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [23:0] CATEGORY_DEFAULT = 24'hFF0000;
    localparam logic [7:0] HOLD_TIMER_RST = 8'h00;
    localparam logic [4:0] HOLD_TIMER_HI_RST = 5'h00;
    localparam int HOLD_TIMER_LSB = 3;
    localparam logic [7:0] HEADER_VALUE = 8'h00;
    localparam logic [7:0] IRQ_ROUTE_RST = 8'hFF;
    localparam logic [7:0] IRQ_PIN_VALUE = 8'h01;
    localparam logic [7:0] BURST_VALUE = 8'h10;
    localparam logic [7:0] INTERVAL_VALUE = 8'h00;
    localparam logic [3:0] WINDOW_LOW_BITS = 4'h0;
    localparam logic [3:0] ALL_LANES = 4'hF;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam int WINDOW_BITS_MAX = 12;
    localparam int WINDOW_BITS_MIN = 1;

    // Dword index of a printed byte offset
    function automatic logic [5:0] dword_of(input logic [7:0] ofs);
        dword_of = ofs[7:2];
    endfunction

    // Byte lane of a printed byte offset
    function automatic int lane_of(input logic [7:0] ofs);
        lane_of = int'(ofs[1:0]);
    endfunction

endpackage

/* File: hdl/pch_config_regs.sv */
// Type-zero configuration header register bank with status flags and window base
`timescale 1ns/1ns
module pch_config_regs #(
    parameter logic [7:0] revision_param = 8'h01,
    parameter logic [23:0] category_param = pch_pkg::CATEGORY_DEFAULT,
    parameter int window_writable_bit_count = 12,
    parameter logic [15:0] board_maker_param = 16'h5A5A,
    parameter logic [15:0] board_variant_param = 16'hA5A5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [5:0] cfgDword,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    output logic [31:0] cfgRdData,
    output logic cfgRdValid,
    input wire logic targetAbortEvt,
    input wire logic masterAbortEvt,
    input wire logic sysErrDriven,
    input wire logic parityErrEvt,
    input wire logic masterStart,
    input wire logic masterActive,
    output logic [7:0] holdCount,
    output logic holdExpired,
    output logic [3:0] masterByteEn,
    input wire logic tgtWrite,
    input wire logic [3:0] tgtByteEn,
    input wire logic [31:0] tgtWrData,
    output logic localWrite,
    output logic [3:0] localByteEn,
    output logic [31:0] localWrData,
    output logic [31:0] windowBase,
    output logic [7:0] irqRoute
);
    import pch_pkg::*;

    // Number of bits below the writable part of the window base
    localparam int WIN_LSB = 32 - window_writable_bit_count;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0] flags_r;
    logic [4:0] holdHi_r;
    logic [31:0] windowReg_r;
    logic [7:0] irqRoute_r;
    logic [7:0] holdCount_r;
    logic holdExpired_r;
    logic [31:0] rdData_r;
    logic rdValid_r;
    logic localWrite_r;
    logic [3:0] localByteEn_r;
    logic [31:0] localWrData_r;
    logic [3:0] masterByteEn_r;
    logic [31:0] windowMask;
    logic [31:0] rdWord;
    logic [3:0] flagSet;
    logic [3:0] flagClr;
    logic statusWr;

    // Byte-lane merge used by the window base dword
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = wd[8*i +: 8];
            end
        end
        lane_merge = res;
    endfunction

    // ------------------------------------------------------------
    // Window base mask: only the top n bits hold an address
    // ------------------------------------------------------------
    always_comb begin
        windowMask = ZERO_WORD;
        for (int i = WIN_LSB; i < 32; i++) begin
            windowMask[i] = 1'b1; // RL11
        end
    end

    // ------------------------------------------------------------
    // Status flags: hardware set wins over a software clear
    // ------------------------------------------------------------
    always_comb begin
        flagSet = '0;
        flagSet[BIT_TGT_ABORT - 12] = targetAbortEvt; // RL1
        flagSet[BIT_MST_ABORT - 12] = masterAbortEvt; // RL2
        flagSet[BIT_SYS_ERR - 12] = sysErrDriven; // RL3
        flagSet[BIT_PAR_ERR - 12] = parityErrEvt; // RL4
        statusWr = cfgWrite && (cfgDword == dword_of(OFS_STATUS)) && cfgByteEn[3];
        flagClr = statusWr ? cfgWrData[STATUS_LANE_LSB + 15 -: 4] : 4'h0; // RL5
    end

    // Ones written clear flags, zeros leave them; writes never set
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_r <= FLAGS_RST;
        end else begin
            flags_r <= (flags_r & ~flagClr) | flagSet; // RL5
        end
    end

    // ------------------------------------------------------------
    // Writable header fields
    // ------------------------------------------------------------
    // Latency timer keeps only bits 7..3; the low three stay zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            holdHi_r <= HOLD_TIMER_HI_RST;
        end else if (cfgWrite && cfgDword == dword_of(OFS_HOLD_TIMER)
                     && cfgByteEn[lane_of(OFS_HOLD_TIMER)]) begin
            holdHi_r <= cfgWrData[8*lane_of(OFS_HOLD_TIMER) + 7 -: 5]; // RL8
        end
    end

    // Window base; bits below the writable part never store, so sizing works
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            windowReg_r <= ZERO_WORD;
        end else if (cfgWrite && cfgDword == dword_of(OFS_WINDOW)) begin
            windowReg_r <= lane_merge(windowReg_r, cfgWrData, cfgByteEn) & windowMask; // RL12
        end
    end

    // Interrupt route, written by system software at power-up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqRoute_r <= IRQ_ROUTE_RST; // RL16
        end else if (cfgWrite && cfgDword == dword_of(OFS_IRQ_ROUTE)
                     && cfgByteEn[lane_of(OFS_IRQ_ROUTE)]) begin
            irqRoute_r <= cfgWrData[8*lane_of(OFS_IRQ_ROUTE) +: 8]; // RL16
        end
    end

    // ------------------------------------------------------------
    // Read mux; unknown dwords and unused bits return zero
    // ------------------------------------------------------------
    always_comb begin
        rdWord = ZERO_WORD; // RL22
        unique case (cfgDword)
            dword_of(OFS_STATUS): begin
                rdWord[STATUS_LANE_LSB + 15 -: 4] = flags_r;
            end
            dword_of(OFS_REVISION): begin
                rdWord[8*lane_of(OFS_REVISION) +: 8] = revision_param; // RL6
                rdWord[8*lane_of(OFS_CATEGORY) +: 24] = category_param; // RL7
            end
            dword_of(OFS_HOLD_TIMER): begin
                rdWord[8*lane_of(OFS_HOLD_TIMER) +: 8] = {holdHi_r, 3'b000}; // RL8
                rdWord[8*lane_of(OFS_HEADER) +: 8] = HEADER_VALUE; // RL10
            end
            dword_of(OFS_WINDOW): begin
                rdWord = {windowReg_r[31:4], WINDOW_LOW_BITS}; // RL13
            end
            dword_of(OFS_MAKER): begin
                rdWord[8*lane_of(OFS_MAKER) +: 16] = board_maker_param; // RL14
                rdWord[8*lane_of(OFS_VARIANT) +: 16] = board_variant_param; // RL15
            end
            dword_of(OFS_IRQ_ROUTE): begin
                rdWord[8*lane_of(OFS_IRQ_ROUTE) +: 8] = irqRoute_r;
                rdWord[8*lane_of(OFS_IRQ_PIN) +: 8] = IRQ_PIN_VALUE; // RL17
                rdWord[8*lane_of(OFS_BURST) +: 8] = BURST_VALUE; // RL18
                rdWord[8*lane_of(OFS_INTERVAL) +: 8] = INTERVAL_VALUE; // RL19
            end
            default: begin
                rdWord = ZERO_WORD; // RL22
            end
        endcase
    end

    // Read answers one clock after the request; data holds until next read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_r <= ZERO_WORD;
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= cfgRead;
            if (cfgRead) begin
                rdData_r <= rdWord;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus-ownership counter: loads at master start, counts down
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            holdCount_r <= HOLD_TIMER_RST;
            holdExpired_r <= 1'b0;
        end else if (masterStart) begin
            holdCount_r <= {holdHi_r, 3'b000};
            holdExpired_r <= ({holdHi_r, 3'b000} == HOLD_TIMER_RST);
        end else if (masterActive) begin
            // Stops at zero so a long tenure cannot wrap and regain time
            if (holdCount_r != HOLD_TIMER_RST) begin
                holdCount_r <= holdCount_r - 8'h01; // RL9
            end
            holdExpired_r <= (holdCount_r <= 8'h01);
        end else begin
            holdExpired_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Data paths: master uses whole words, target writes keep lanes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            masterByteEn_r <= 4'h0;
        end else begin
            masterByteEn_r <= ALL_LANES; // RL20
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            localWrite_r <= 1'b0;
            localByteEn_r <= 4'h0;
            localWrData_r <= ZERO_WORD;
        end else begin
            localWrite_r <= tgtWrite;
            localByteEn_r <= tgtWrite ? tgtByteEn : 4'h0; // RL21
            if (tgtWrite) begin
                localWrData_r <= tgtWrData;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    assign cfgRdData = rdData_r;
    assign cfgRdValid = rdValid_r;
    assign holdCount = holdCount_r;
    assign holdExpired = holdExpired_r;
    assign masterByteEn = masterByteEn_r;
    assign localWrite = localWrite_r;
    assign localByteEn = localByteEn_r;
    assign localWrData = localWrData_r;
    assign windowBase = windowReg_r;
    assign irqRoute = irqRoute_r;

endmodule

/* File: tb/pch_config_regs_asserts.sv */
// Port-level checks for the configuration header register bank
`timescale 1ns/1ns
module pch_config_regs_asserts #(
    parameter int window_writable_bit_count = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfgRead,
    input wire logic cfgWrite,
    input wire logic [5:0] cfgDword,
    input wire logic [3:0] cfgByteEn,
    input wire logic [31:0] cfgWrData,
    input wire logic [31:0] cfgRdData,
    input wire logic cfgRdValid,
    input wire logic targetAbortEvt,
    input wire logic parityErrEvt,
    input wire logic masterStart,
    input wire logic masterActive,
    input wire logic [7:0] holdCount,
    input wire logic holdExpired,
    input wire logic [3:0] masterByteEn,
    input wire logic [31:0] windowBase,
    input wire logic [7:0] irqRoute
);
    // ----------------------------------------------------------------
    // One clock domain, so clocking and reset are given once
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    localparam int LowTop = 31 - window_writable_bit_count;

    a_read_answer: assert property (cfgRead |=> cfgRdValid)
        else $error("read not answered");
    a_abort_flag: assert property (targetAbortEvt ##1 (cfgRead && cfgDword == 6'h01)
        |=> cfgRdData[28]) else $error("abort flag not set");
    // Clear must stick when no new parity event races it
    a_flag_clear: assert property ((cfgWrite && cfgDword == 6'h01 && cfgByteEn[3]
        && cfgWrData[31] && !parityErrEvt) ##1 !parityErrEvt ##1 (cfgRead && cfgDword == 6'h01)
        |=> !cfgRdData[31]) else $error("flag not cleared");
    a_timer_low: assert property (masterStart |=> holdCount[2:0] == 3'h0)
        else $error("timer low bits set");
    a_timer_step: assert property (masterActive && !masterStart && holdCount != 8'h00
        |=> holdCount == $past(holdCount) - 8'h01) else $error("timer not decremented");
    a_timer_out: assert property (masterActive && !masterStart && holdCount == 8'h01
        |=> holdExpired) else $error("timer expiry missed");
    a_window_low: assert property (windowBase[LowTop:0] == '0)
        else $error("window low bits set");
    a_route_write: assert property (cfgWrite && cfgDword == 6'h0F && cfgByteEn[0]
        |=> irqRoute == $past(cfgWrData[7:0])) else $error("route not written");
    a_master_lanes: assert property (!sys_rst |=> masterByteEn == 4'hF)
        else $error("master lanes not all on");

    cover property (masterActive && holdCount == 8'h01);
    cover property (cfgWrite && cfgDword == 6'h04);
    cover property (targetAbortEvt ##1 cfgRead);
endmodule

/* File: tb/pch_host_model.sv */
// Host model issuing single configuration reads and writes
`timescale 1ns/1ns
module pch_host_model (
    input wire logic clk,
    output logic cfgRead,
    output logic cfgWrite,
    output logic [5:0] cfgDword,
    output logic [3:0] cfgByteEn,
    output logic [31:0] cfgWrData
);
    // Idle bus at time zero
    initial begin
        {cfgRead, cfgWrite, cfgDword, cfgByteEn, cfgWrData} = '0;
    end

    // One request held over exactly one sampling edge
    task automatic req(input logic rd, input logic [5:0] dw, input logic [3:0] be,
                       input logic [31:0] d);
        @(posedge clk);
        #5 cfgRead = rd;
        cfgWrite = !rd;
        cfgDword = dw;
        cfgByteEn = be;
        cfgWrData = d;
        @(posedge clk);
        // Released lines flip so a stale value never looks live
        #5 cfgRead = 1'b0;
        cfgWrite = 1'b0;
        cfgDword = ~cfgDword;
        cfgByteEn = ~cfgByteEn;
        cfgWrData = ~cfgWrData;
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the configuration header register bank
`timescale 1ns/1ns
module tb_top;
    import pch_pkg::*;
    // Arbitrary build codes, chosen only to be recognisable
    localparam logic [7:0] REV = 8'h3C;
    localparam logic [15:0] MAKER = 16'h1D2E;
    localparam logic [15:0] VARIANT = 16'h7B40;
    localparam int NBITS = 4;
    logic clk, sys_rst, cfgRead, cfgWrite, cfgRdValid, masterStart, masterActive;
    logic holdExpired, tgtWrite, localWrite;
    logic [5:0] cfgDword;
    logic [3:0] cfgByteEn, masterByteEn, tgtByteEn, localByteEn, ev;
    logic [31:0] cfgWrData, cfgRdData, tgtWrData, localWrData, windowBase, r;
    logic [7:0] holdCount, irqRoute;
    logic [31:0] expq[$];
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    integer seed = 32'hc1883df9;

    pch_config_regs #(.revision_param(REV), .window_writable_bit_count(NBITS),
        .board_maker_param(MAKER), .board_variant_param(VARIANT)) uut (
        .clk, .sys_rst, .cfgRead, .cfgWrite, .cfgDword, .cfgByteEn, .cfgWrData, .cfgRdData,
        .cfgRdValid, .targetAbortEvt(ev[0]), .masterAbortEvt(ev[1]), .sysErrDriven(ev[2]),
        .parityErrEvt(ev[3]), .masterStart, .masterActive, .holdCount, .holdExpired,
        .masterByteEn, .tgtWrite, .tgtByteEn, .tgtWrData, .localWrite, .localByteEn,
        .localWrData, .windowBase, .irqRoute);
    pch_host_model host (.clk, .cfgRead, .cfgWrite, .cfgDword, .cfgByteEn, .cfgWrData);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
        expq.push_back(exp);
        host.req(1'b1, dw, 4'h0, 32'h0);
    endtask
    task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
        host.req(1'b0, dw, be, d);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            wrap_up();
        end
    end
    // Read answers matched against the oldest note; an unasked answer never matches
    // Sampled mid-cycle so the registered answer has settled after its launch edge
    always @(negedge clk) begin
        if (cfgRdValid === 1'b1) begin
            chk(cfgRdData, (expq.size() > 0) ? expq.pop_front() : 32'hx);
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [5:0] dw [7];
        logic [31:0] e0 [7];
        logic [31:0] e1 [7];
        dw = '{6'h02, 6'h03, 6'h04, 6'h0B, 6'h0F, 6'h05, 6'h01};
        e0 = '{{CATEGORY_DEFAULT, REV}, 32'h0, 32'h0, {VARIANT, MAKER}, 32'h001001FF, 32'h0, 32'h0};
        e1 = e0;
        e1[1] = 32'h0000F800;
        e1[2] = 32'hF0000000;
        {sys_rst, masterStart, masterActive, tgtWrite, ev, tgtByteEn} = 12'h800;
        tgtWrData = 32'h0;
        repeat (16) @(posedge clk);
        #5 sys_rst = 1'b0;
        for (int i = 0; i < 7; i++) rd(dw[i], e0[i]);
        for (int i = 0; i < 7; i++) wr(dw[i], 4'hF, 32'hFFFFFFFF);
        for (int i = 0; i < 7; i++) rd(dw[i], e1[i]);
        wr(6'h04, 4'h7, 32'h0);
        rd(6'h04, 32'hF0000000);
        chk(windowBase, 32'hF0000000);
        r = $random(seed);
        wr(6'h0F, 4'hF, r);
        rd(6'h0F, {24'h001001, r[7:0]});
        // Each event alone, read straight after it lands
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #5 ev = 4'h1 << i;
            fork
                begin @(posedge clk); #5 ev = 4'h0; end
                rd(6'h01, {4'hF >> (3 - i), 28'h0});
            join
        end
        wr(6'h01, 4'h8, 32'h40000000);
        rd(6'h01, 32'hB0000000);
        wr(6'h01, 4'h7, 32'hFFFFFFFF);
        rd(6'h01, 32'hB0000000);
        wr(6'h01, 4'h8, 32'hF0000000);
        rd(6'h01, 32'h0);
        wr(6'h03, 4'h2, 32'h00000F00);
        rd(6'h03, 32'h00000800);
        @(posedge clk);
        #5 masterStart = 1'b1;
        @(posedge clk);
        #5 masterStart = 1'b0;
        masterActive = 1'b1;
        chk({24'h0, holdCount}, 32'h8);
        repeat (8) @(posedge clk);
        #5 chk({23'h0, holdExpired, holdCount}, 32'h100);
        masterActive = 1'b0;
        chk({28'h0, masterByteEn}, 32'hF);
        r = $random(seed);
        @(posedge clk);
        #5 tgtWrite = 1'b1;
        tgtByteEn = r[3:0];
        tgtWrData = ~r;
        @(posedge clk);
        #5 tgtWrite = 1'b0;
        chk(localWrData, ~r);
        chk({27'h0, localWrite, localByteEn}, {27'h1, r[3:0]});
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule

bind pch_config_regs pch_config_regs_asserts #(
    .window_writable_bit_count(window_writable_bit_count)) chk_i (
    .clk, .sys_rst, .cfgRead, .cfgWrite, .cfgDword, .cfgByteEn, .cfgWrData, .cfgRdData,
    .cfgRdValid, .targetAbortEvt, .parityErrEvt, .masterStart, .masterActive, .holdCount,
    .holdExpired, .masterByteEn, .windowBase, .irqRoute);
